// ==== rtl/dsq_top.sv ====
// descriptor-driven transfer sequencer of a multi-channel dma engine
`timescale 1ns/1ns
`include "dsq_params.svh"
module dsq_top #(
  parameter int NCH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire dsq_pkg::dsq_word_t wb_dat_i,
  output dsq_pkg::dsq_word_t wb_dat_o,
  output logic wb_ack_o,
  // channel requests and completion pulses
  input wire logic [NCH-1:0] dma_req_i,
  output logic [NCH-1:0] done_o,
  // system memory master
  output logic mem_req_o,
  output logic mem_we_o,
  output dsq_pkg::dsq_word_t mem_addr_o,
  output dsq_pkg::dsq_word_t mem_wdata_o,
  output logic [1:0] mem_size_o,
  input wire logic mem_ack_i,
  input wire dsq_pkg::dsq_word_t mem_rdata_i
);
  import dsq_pkg::*;
  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

  // ==========================================================
  // helpers
  function automatic dsq_word_t merge(dsq_word_t o, dsq_word_t n,
                                      logic [3:0] s);
    dsq_word_t r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  // lowest set bit wins, the flag above the index says one was found
  function automatic logic [CW:0] pick(logic [NCH-1:0] v);
    logic [CW:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, CW'(i)};
      end
    end
    return r;
  endfunction

  // current address from the last pointer and the remaining count
  function automatic dsq_word_t step_addr(dsq_word_t last, logic [9:0] n,
                                          logic [1:0] step);
    dsq_word_t off;
    off = {22'h0, n} << step;
    return (step == `DSQ_STEP_NONE) ? last : last - off;
  endfunction

  // ==========================================================
  // state
  dsq_state_e st_q, st_d;
  logic [CW-1:0] ch_q, ch_d;
  dsq_word_t ctl_q, ctl_d, sptr_q, dptr_q, base_q;
  logic [10:0] left_q, left_d;
  logic fin_q, fin_d, en_q, err_q;
  logic [NCH-1:0] chen_q, hipri_q, pend_q, alt_q, sg_q;
  logic [NCH-1:0] req_m_q, req_s_q, req_p_q;

  // ==========================================================
  // request pins: two flops, then edge detect on the settled copy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_m_q <= '0;
      req_s_q <= '0;
      req_p_q <= '0;
    end else begin
      req_m_q <= dma_req_i;
      req_s_q <= req_m_q;
      req_p_q <= req_s_q;
    end
  end
  wire [NCH-1:0] req_rise = req_s_q & ~req_p_q;

  // ==========================================================
  // control word fields
  wire [9:0] cnt = ctl_q[`DSQ_CNT_LSB +: 10];
  wire [1:0] dstep = ctl_q[`DSQ_DINC_LSB +: 2];
  wire [1:0] dwid = ctl_q[`DSQ_DWID_LSB +: 2];
  wire [1:0] sstep = ctl_q[`DSQ_SINC_LSB +: 2];
  wire [1:0] swid = ctl_q[`DSQ_SWID_LSB +: 2];
  wire [3:0] rpow = ctl_q[`DSQ_RPOW_LSB +: 4];
  wire dsq_cyc_e cyc = dsq_cyc_e'(ctl_q[2:0]);
  wire is_stop = cyc == CYC_STOP;
  wire is_pri = cyc == CYC_MSG_PRI || cyc == CYC_PSG_PRI;
  wire is_alt = cyc == CYC_MSG_ALT || cyc == CYC_PSG_ALT;
  wire is_burst = cyc == CYC_AUTO || is_pri || is_alt;
  // reserved widths, unequal widths and steps below the width are refused
  wire cfg_bad = dwid == `DSQ_WID_RSVD || swid == `DSQ_WID_RSVD ||
                 dwid != swid ||
                 (sstep != `DSQ_STEP_NONE && sstep < swid) ||
                 (dstep != `DSQ_STEP_NONE && dstep < swid);
  // burst size: basic and ping-pong serve one transfer per grant
  wire [10:0] nleft = {1'b0, cnt} + 11'h1;
  wire [10:0] pw = (rpow >= `DSQ_RPOW_CAP) ? `DSQ_BURST_MAX :
                   (11'h1 << rpow);
  wire [10:0] burst = !is_burst ? 11'h1 :
                      (pw < nleft) ? pw : nleft;

  // ==========================================================
  // arbitration over enabled pending channels
  wire [NCH-1:0] rdy = pend_q & chen_q & {NCH{en_q}};
  wire [CW:0] gh = pick(rdy & hipri_q);
  wire [CW:0] gl = pick(rdy);
  wire any_rdy = gl[CW];
  wire [CW-1:0] grant = gh[CW] ? gh[CW-1:0] : gl[CW-1:0];

  // ==========================================================
  // sequencer next state
  always_comb begin
    st_d = st_q;
    ch_d = ch_q;
    ctl_d = ctl_q;
    left_d = left_q;
    fin_d = fin_q;
    case (st_q)
      ST_IDLE: begin
        if (any_rdy) begin
          st_d = ST_RD_SPTR;
          ch_d = grant;
          fin_d = 1'b0;
        end
      end
      ST_RD_SPTR: begin
        if (mem_ack_i) begin
          st_d = ST_RD_DPTR;
        end
      end
      ST_RD_DPTR: begin
        if (mem_ack_i) begin
          st_d = ST_RD_CTL;
        end
      end
      ST_RD_CTL: begin
        if (mem_ack_i) begin
          st_d = ST_DECODE;
          ctl_d = mem_rdata_i;
        end
      end
      ST_DECODE: begin
        if (is_stop || cfg_bad) begin
          st_d = ST_IDLE;
        end else begin
          st_d = ST_SRC_RD;
          left_d = burst;
        end
      end
      ST_SRC_RD: begin
        if (mem_ack_i) begin
          st_d = ST_DST_WR;
        end
      end
      ST_DST_WR: begin
        if (mem_ack_i) begin
          left_d = left_q - 11'h1;
          if (cnt == 10'h0) begin
            fin_d = 1'b1;
          end else begin
            ctl_d[`DSQ_CNT_LSB +: 10] = cnt - 10'h1;
          end
          // burst over or cycle done: write back before arbitrating
          if (cnt == 10'h0 || left_q == 11'h1) begin
            st_d = ST_WB_CTL;
          end else begin
            st_d = ST_SRC_RD;
          end
        end
      end
      ST_WB_CTL: begin
        if (mem_ack_i) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // ==========================================================
  // memory access for the state being entered
  wire dsq_word_t dbase = base_q + (alt_q[ch_d] ? `DSQ_D_ALT : 32'h0) +
                          (32'(ch_d) << `DSQ_D_STRIDE_LOG2);
  wire dsq_word_t wb_word = fin_d ? {ctl_d[31:3], CYC_STOP} : ctl_d;
  wire data_st = st_d == ST_SRC_RD || st_d == ST_DST_WR;
  wire req_d = st_d != ST_IDLE && st_d != ST_DECODE;
  wire dsq_word_t addr_d =
    (st_d == ST_RD_SPTR) ? dbase + `DSQ_D_SRC :
    (st_d == ST_RD_DPTR) ? dbase + `DSQ_D_DST :
    (st_d == ST_SRC_RD) ? step_addr(sptr_q,
                          ctl_d[`DSQ_CNT_LSB +: 10], sstep) :
    (st_d == ST_DST_WR) ? step_addr(dptr_q,
                          ctl_d[`DSQ_CNT_LSB +: 10], dstep) :
    dbase + `DSQ_D_CTL;
  wire dsq_word_t wdata_d = (st_d != ST_DST_WR) ? wb_word :
                            (st_q == ST_SRC_RD) ? mem_rdata_i : mem_wdata_o;

  // sequencer registers; memory outputs change only between accesses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      ch_q <= '0;
      ctl_q <= `DSQ_RST_WORD;
      left_q <= '0;
      fin_q <= 1'b0;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= `DSQ_RST_WORD;
      mem_wdata_o <= `DSQ_RST_WORD;
      mem_size_o <= `DSQ_WORD_SZ;
    end else begin
      st_q <= st_d;
      ch_q <= ch_d;
      ctl_q <= ctl_d;
      left_q <= left_d;
      fin_q <= fin_d;
      mem_req_o <= req_d;
      mem_we_o <= st_d == ST_DST_WR || st_d == ST_WB_CTL;
      mem_addr_o <= addr_d;
      mem_wdata_o <= wdata_d;
      mem_size_o <= data_st ? ctl_d[`DSQ_SWID_LSB +: 2] : `DSQ_WORD_SZ;
    end
  end

  // pointers are caught as they come back from memory
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sptr_q <= `DSQ_RST_WORD;
      dptr_q <= `DSQ_RST_WORD;
    end else begin
      if (st_q == ST_RD_SPTR && mem_ack_i) sptr_q <= mem_rdata_i;
      if (st_q == ST_RD_DPTR && mem_ack_i) dptr_q <= mem_rdata_i;
    end
  end

  // ==========================================================
  // per-channel bookkeeping at the end of each service
  wire [NCH-1:0] ch_oh = NCH'(1) << ch_q;
  wire sgc = sg_q[ch_q];
  wire alt_cur = alt_q[ch_q];
  wire wbk = st_q == ST_WB_CTL && mem_ack_i;
  wire dec_inv = st_q == ST_DECODE && is_stop;
  wire dec_bad = st_q == ST_DECODE && !is_stop && cfg_bad;
  // scatter-gather and unfinished autorequest keep their own request
  wire keep = is_pri || is_alt || (cyc == CYC_AUTO && !fin_q) ||
              (cyc == CYC_BASIC && sgc && !fin_q);
  wire pend_clr = dec_inv || dec_bad || (wbk && !keep);
  wire done_ev = wbk && fin_q && (cyc == CYC_BASIC ||
                 cyc == CYC_AUTO || cyc == CYC_PINGPONG);
  wire alt_flip = wbk && ((cyc == CYC_PINGPONG && fin_q) ||
                  is_pri || (is_alt && fin_q));
  wire sg_end = sgc && (dec_inv || dec_bad ||
                (wbk && fin_q && cyc == CYC_BASIC));

  // ==========================================================
  // wishbone slave: one wait state, every address answers
  // writes land on the edge that samples ack, as the master expects
  wire wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire sel_ctrl = wb_adr_i == `DSQ_R_CTRL;
  wire sel_base = wb_adr_i == `DSQ_R_BASE;
  wire sel_chen = wb_adr_i == `DSQ_R_CHEN;
  wire sel_hipri = wb_adr_i == `DSQ_R_HIPRI;
  wire sel_swreq = wb_adr_i == `DSQ_R_SWREQ;
  wire sel_alt = wb_adr_i == `DSQ_R_ALT;
  wire sel_stat = wb_adr_i == `DSQ_R_STAT;
  wire dsq_word_t wmask = merge(32'h0, wb_dat_i, wb_sel_i);
  wire dsq_word_t chen_w = merge(32'(chen_q), wb_dat_i, wb_sel_i);
  wire dsq_word_t hipri_w = merge(32'(hipri_q), wb_dat_i, wb_sel_i);
  wire dsq_word_t alt_w = merge(32'(alt_q), wb_dat_i, wb_sel_i);
  wire [NCH-1:0] sw_set = (wb_wr && sel_swreq) ? wmask[NCH-1:0] : '0;
  wire err_clr = wb_wr && sel_stat && wmask[`DSQ_STAT_ERR];
  wire dsq_word_t stat_w = {15'h0, err_q, 3'h0, 5'(ch_q), 7'h0,
                            st_q != ST_IDLE};
  wire dsq_word_t rd_val = sel_ctrl ? {31'h0, en_q} :
                           sel_base ? base_q :
                           sel_chen ? 32'(chen_q) :
                           sel_hipri ? 32'(hipri_q) :
                           sel_swreq ? 32'(pend_q) :
                           sel_alt ? 32'(alt_q) :
                           sel_stat ? stat_w : 32'h0;

  // bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `DSQ_RST_WORD;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= (wb_hit && !wb_we_i) ? rd_val : 32'h0;
    end
  end

  // software registers and channel flags; a set beats a clear, but a write to the alt register beats any hardware change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      base_q <= `DSQ_RST_WORD;
      chen_q <= '0;
      hipri_q <= '0;
      pend_q <= '0;
      alt_q <= '0;
      sg_q <= '0;
      err_q <= 1'b0;
      done_o <= '0;
    end else begin
      if (wb_wr && sel_ctrl && wb_sel_i[0]) en_q <= wb_dat_i[0];
      if (wb_wr && sel_base) base_q <= merge(base_q, wb_dat_i, wb_sel_i);
      if (wb_wr && sel_chen) chen_q <= chen_w[NCH-1:0];
      if (wb_wr && sel_hipri) hipri_q <= hipri_w[NCH-1:0];
      pend_q <= (pend_q & ~({NCH{pend_clr}} & ch_oh)) |
                req_rise | sw_set;
      if (wb_wr && sel_alt) begin
        alt_q <= alt_w[NCH-1:0];
      end else if (alt_flip) begin
        alt_q <= alt_q ^ ch_oh;
      end else if (sg_end) begin
        alt_q <= alt_q & ~ch_oh;
      end
      if (wbk && is_pri) begin
        sg_q <= sg_q | ch_oh;
      end else if (sg_end) begin
        sg_q <= sg_q & ~ch_oh;
      end
      err_q <= dec_bad || (err_q && !err_clr);
      done_o <= {NCH{done_ev}} & ch_oh;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_last_xfer;
    st_q == ST_DST_WR && mem_ack_i && cnt == 10'h0;
  endsequence
  sequence s_wb_invalid;
    st_q == ST_WB_CTL && mem_req_o && mem_wdata_o[2:0] == 3'h0;
  endsequence

  chk_stop_no_xfer: assert property (
    st_q == ST_DECODE && is_stop |=> st_q == ST_IDLE ##1 !mem_we_o)
    else $error("stop descriptor started a transfer");
  chk_src_addr: assert property (
    st_q == ST_SRC_RD && mem_req_o |->
      mem_addr_o == step_addr(sptr_q, cnt, sstep))
    else $error("source address wrong");
  chk_dst_fixed: assert property (
    st_q == ST_DST_WR && mem_req_o && dstep == `DSQ_STEP_NONE |->
      mem_addr_o == dptr_q && mem_we_o)
    else $error("fixed destination moved");
  chk_wb_count: assert property (
    st_q == ST_DST_WR && mem_ack_i && cnt != 10'h0 && left_q == 11'h1 |=>
      mem_we_o && mem_wdata_o[`DSQ_CNT_LSB +: 10] == $past(cnt) - 10'h1)
    else $error("written back count wrong");
  chk_invalidate: assert property (
    s_last_xfer |=> s_wb_invalid)
    else $error("finished cycle not invalidated");
  chk_basic_one: assert property (
    st_q == ST_DST_WR && mem_ack_i && cyc == CYC_BASIC |=>
      st_q == ST_WB_CTL)
    else $error("basic cycle ran more than one transfer");
  chk_done_pulse: assert property (
    wbk && fin_q && cyc == CYC_AUTO |=> done_o == $past(ch_oh) ##1 done_o == '0)
    else $error("completion pulse wrong");
  chk_burst_len: assert property (
    st_q == ST_DECODE && is_burst && !cfg_bad |=>
      left_q <= $past(nleft) && left_q <= $past(pw))
    else $error("burst exceeds limit");
  chk_auto_rereq: assert property (
    wbk && cyc == CYC_AUTO && !fin_q |=> pend_q[$past(ch_q)])
    else $error("autorequest lost its request");
  chk_pp_toggle: assert property (
    wbk && cyc == CYC_PINGPONG && fin_q |=> alt_q[$past(ch_q)] != $past(alt_cur))
    else $error("ping-pong did not alternate");
  chk_sg_to_alt: assert property (
    wbk && is_pri |=> alt_q[$past(ch_q)] && pend_q[$past(ch_q)])
    else $error("scatter-gather did not move to alternate");
  chk_arb_prio: assert property (
    st_q == ST_IDLE && (rdy & hipri_q) != '0 |=> hipri_q[ch_q])
    else $error("default channel beat a high one");
  chk_bad_cfg: assert property (
    dec_bad |=> st_q == ST_IDLE && err_q)
    else $error("bad width accepted");
endmodule

// ==== rtl/dsq_params.svh ====
// offsets, field positions and reset values of the descriptor sequencer
`ifndef DSQ_PARAMS_SVH
`define DSQ_PARAMS_SVH
// control word field positions
`define DSQ_DINC_LSB 30
`define DSQ_DWID_LSB 28
`define DSQ_SINC_LSB 26
`define DSQ_SWID_LSB 24
`define DSQ_RPOW_LSB 14
`define DSQ_CNT_LSB 4
// encodings
`define DSQ_STEP_NONE 2'h3
`define DSQ_WID_RSVD 2'h3
`define DSQ_WORD_SZ 2'h2
`define DSQ_RPOW_CAP 4'ha
`define DSQ_BURST_MAX 11'h400
// descriptor layout in system memory
`define DSQ_D_SRC 32'h0
`define DSQ_D_DST 32'h4
`define DSQ_D_CTL 32'h8
`define DSQ_D_ALT 32'h200
`define DSQ_D_STRIDE_LOG2 4
// register byte offsets
`define DSQ_R_CTRL 8'h00
`define DSQ_R_BASE 8'h04
`define DSQ_R_CHEN 8'h08
`define DSQ_R_HIPRI 8'h0c
`define DSQ_R_SWREQ 8'h10
`define DSQ_R_ALT 8'h14
`define DSQ_R_STAT 8'h18
`define DSQ_STAT_ERR 16
// reset values
`define DSQ_RST_WORD 32'h0
`endif

// ==== rtl/dsq_pkg.sv ====
// types shared by the descriptor cycle sequencer
package dsq_pkg;
  typedef logic [31:0] dsq_word_t;
  typedef enum logic [2:0] {
    CYC_STOP = 3'h0, CYC_BASIC = 3'h1, CYC_AUTO = 3'h2, CYC_PINGPONG = 3'h3,
    CYC_MSG_PRI = 3'h4, CYC_MSG_ALT = 3'h5, CYC_PSG_PRI = 3'h6,
    CYC_PSG_ALT = 3'h7
  } dsq_cyc_e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_SPTR, ST_RD_DPTR, ST_RD_CTL, ST_DECODE, ST_SRC_RD,
    ST_DST_WR, ST_WB_CTL
  } dsq_state_e;
endpackage

// ==== tb/dsq_mem_model.sv ====
// system memory model answering the sequencer's master port
`timescale 1ns/1ns
module dsq_mem_model (
  // clock
  input wire logic clk_i,
  // master port of the sequencer
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  input wire logic [1:0] mem_size_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  // ==========================================
  // storage, descriptors of four words from 0x000
  logic [31:0] mem [0:1023];
  logic [31:0] rd_q;
  logic [1:0] gap_q;

  // empty memory, no answer pending
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    rd_q = 32'h0;
    gap_q = 2'h0;
    mem_ack_o = 1'b0;
  end

  // data is not held past ack: show its inverse so stale use shows
  assign mem_rdata_o = mem_ack_o ? rd_q : ~rd_q;

  // one-cycle ack after 0 to 3 wait cycles, prompt and slow mixed
  always @(posedge clk_i) begin
    if (mem_ack_o) begin
      mem_ack_o <= 1'b0;
    end else if (mem_req_i && gap_q != 2'h0) begin
      gap_q <= gap_q - 2'h1;
    end else if (mem_req_i) begin
      mem_ack_o <= 1'b1;
      gap_q <= mem_addr_i[4:3];
      rd_q <= mem[mem_addr_i[11:2]] >> (8 * mem_addr_i[1:0]);
      if (mem_we_i && mem_size_i == 2'h0)
        mem[mem_addr_i[11:2]][8 * mem_addr_i[1:0] +: 8] <= mem_wdata_i[7:0];
      if (mem_we_i && mem_size_i == 2'h1)
        mem[mem_addr_i[11:2]][8 * mem_addr_i[1:0] +: 16] <= mem_wdata_i[15:0];
      if (mem_we_i && mem_size_i == 2'h2)
        mem[mem_addr_i[11:2]] <= mem_wdata_i;
    end
  end
endmodule

// ==== tb/dma_descriptor_cycle_sequencer_test.sv ====
// self-checking bench for the descriptor cycle sequencer
`timescale 1ns/1ns
`include "dsq_params.svh"
module dma_descriptor_cycle_sequencer_test;
  import dsq_pkg::*;
  // ==========================================
  // signals
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic mem_req_o, mem_we_o, mem_ack_i;
  logic [7:0] wb_adr_i, dma_req_i, done_o;
  logic [3:0] wb_sel_i;
  logic [1:0] mem_size_o;
  dsq_word_t wb_dat_i, wb_dat_o, mem_addr_o, mem_wdata_o, mem_rdata_i, rd;
  dsq_word_t bad[3];
  int n_fail, checks_done, seed, n, ndone[8], order[$];

  dsq_top #(.NCH(8)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dma_req_i(dma_req_i),
    .done_o(done_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_size_o(mem_size_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i));

  dsq_mem_model u_mem (.clk_i(clk_i), .mem_req_i(mem_req_o),
    .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_size_i(mem_size_o),
    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // count completion pulses and keep their order
  always @(posedge clk_i) begin
    for (int k = 0; k < 8; k++) begin
      if (done_o[k] === 1'b1) begin
        ndone[k]++;
        order.push_back(k);
      end
    end
  end

  // ==========================================
  // helpers
  function automatic dsq_word_t cw(input logic [1:0] ds, input logic [1:0] ss,
      input logic [1:0] w, input logic [3:0] p, input logic [9:0] n1,
      input logic [2:0] cy);
    return {ds, w, ss, w, 6'h0, p, n1, 1'b0, cy};
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input dsq_word_t e, input dsq_word_t g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle, held until ack, then a cycle with cyc low
  task automatic wb(input logic we, input logic [7:0] a, input dsq_word_t d);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i == 20) begin
      chk("wb ack", 1, 0);
      wrap_up;
    end
    @(posedge clk_i);
  endtask

  // poll until nothing pending and the engine is not busy
  task automatic settle;
    int i;
    for (i = 0; i < 400; i++) begin
      wb(1'b0, `DSQ_R_SWREQ, 0);
      if (rd === 32'h0) begin
        wb(1'b0, `DSQ_R_STAT, 0);
        if (rd[0] === 1'b0) break;
      end
    end
    if (i == 400) begin
      chk("settle", 1, 0);
      wrap_up;
    end
  endtask

  task automatic go(input int ch);
    wb(1'b1, `DSQ_R_SWREQ, 32'h1 << ch);
    settle;
  endtask

  task automatic desc(input int ch, input int alt, input dsq_word_t s,
      input dsq_word_t d, input dsq_word_t c);
    int b;
    b = (alt * `DSQ_D_ALT + ch * 16) / 4;
    u_mem.mem[b] = s;
    u_mem.mem[b + 1] = d;
    u_mem.mem[b + 2] = c;
    u_mem.mem[b + 3] = 32'h0;
  endtask

  // ==========================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    dma_req_i = 8'h0;
    n_fail = 0;
    checks_done = 0;
    seed = 21753;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset idle", 0, {mem_req_o, done_o});
    wb(1'b1, 8'h1c, 32'hffffffff);
    wb(1'b0, 8'h1c, 0);
    chk("unmapped read", 0, rd);
    wb(1'b0, `DSQ_R_CTRL, 0);
    chk("ctrl reset", 0, rd);
    wb(1'b1, `DSQ_R_CTRL, 1);
    wb(1'b1, `DSQ_R_BASE, 0);
    wb(1'b1, `DSQ_R_CHEN, 32'hff);
    for (int i = 0; i < 8; i++) u_mem.mem[256 + i] = $random(seed);
    // basic cycle, three words, first request from the pin
    desc(0, 0, 32'h408, 32'h508, cw(2'h2, 2'h2, 2'h2, 4'h0, 10'h2, 3'h1));
    dma_req_i <= 8'h1;
    repeat (4) @(posedge clk_i);
    dma_req_i <= 8'h0;
    repeat (4) @(posedge clk_i);
    settle;
    chk("basic word", u_mem.mem[256], u_mem.mem[320]);
    chk("basic single", 0, u_mem.mem[321]);
    chk("basic wb", cw(2, 2, 2, 0, 10'h1, 3'h1), u_mem.mem[2]);
    chk("basic early", 0, ndone[0]);
    go(0);
    go(0);
    for (int i = 1; i < 3; i++) chk("basic word", u_mem.mem[256 + i], u_mem.mem[320 + i]);
    chk("basic invalid", 0, u_mem.mem[2] & 32'h7);
    chk("basic done", 1, ndone[0]);
    // autorequest of random length, bursts of two, one request
    n = 3 + {$random(seed)} % 5;
    desc(1, 0, 32'h400 + 4 * (n - 1), 32'h600 + 4 * (n - 1),
      cw(2, 2, 2, 4'h1, 10'(n - 1), 3'h2));
    go(1);
    for (int i = 0; i < n; i++) chk("auto word", u_mem.mem[256 + i], u_mem.mem[384 + i]);
    chk("auto end", 0, u_mem.mem[384 + n]);
    chk("auto done", 1, ndone[1]);
    // fixed destination, then fixed source
    desc(2, 0, 32'h40c, 32'h700, cw(2'h3, 2'h2, 2'h2, 4'h2, 10'h3, 3'h2));
    go(2);
    chk("fixed dest", u_mem.mem[259], u_mem.mem[448]);
    chk("fixed dest only", 0, u_mem.mem[447]);
    desc(2, 0, 32'h400, 32'h71c, cw(2'h2, 2'h3, 2'h2, 4'h2, 10'h3, 3'h2));
    go(2);
    chk("fixed src", u_mem.mem[256], u_mem.mem[452]);
    chk("fixed src", u_mem.mem[256], u_mem.mem[455]);
    // byte steps and byte width: four single-byte moves into one word
    desc(2, 0, 32'h403, 32'h783, cw(2'h0, 2'h0, 2'h0, 4'h2, 10'h3, 3'h2));
    go(2);
    chk("byte steps", u_mem.mem[256], u_mem.mem[480]);
    // stopped descriptor, then refused descriptors
    desc(3, 0, 32'h400, 32'h800, cw(2, 2, 2, 0, 10'h0, 3'h0));
    go(3);
    chk("stop no write", 0, u_mem.mem[512]);
    chk("stop kept", cw(2, 2, 2, 0, 10'h0, 3'h0), u_mem.mem[14]);
    bad[0] = cw(2'h3, 2'h3, 2'h3, 4'h0, 10'h0, 3'h1);
    bad[1] = cw(2'h2, 2'h2, 2'h2, 4'h0, 10'h0, 3'h1) ^ 32'h3000_0000;
    bad[2] = cw(2'h0, 2'h0, 2'h2, 4'h0, 10'h0, 3'h1);
    for (int k = 0; k < 3; k++) begin
      desc(3, 0, 32'h400, 32'h800, bad[k]);
      go(3);
      wb(1'b0, `DSQ_R_STAT, 0);
      chk("refused flag", 1, rd[`DSQ_STAT_ERR]);
      chk("refused write", 0, u_mem.mem[512]);
      chk("refused kept", bad[k], u_mem.mem[14]);
      wb(1'b1, `DSQ_R_STAT, 32'h1 << `DSQ_STAT_ERR);
    end
    chk("refused done", 0, ndone[3]);
    // ping-pong, both halves prepared first
    desc(4, 0, 32'h400, 32'h900, cw(2, 2, 2, 0, 10'h0, 3'h3));
    desc(4, 1, 32'h404, 32'h904, cw(2, 2, 2, 0, 10'h0, 3'h3));
    for (int k = 0; k < 3; k++) begin
      go(4);
      chk("pingpong done", k < 2 ? k + 1 : 2, ndone[4]);
    end
    chk("ping word", u_mem.mem[256], u_mem.mem[576]);
    chk("pong word", u_mem.mem[257], u_mem.mem[577]);
    // scatter-gather: one task ending in a basic cycle
    u_mem.mem[640] = 32'h408;
    u_mem.mem[641] = 32'hb14;
    u_mem.mem[642] = cw(2, 2, 2, 0, 10'h1, 3'h1);
    u_mem.mem[643] = 32'h0;
    desc(5, 0, 32'ha0c, 32'h25c, cw(2, 2, 2, 4'h2, 10'h3, 3'h4));
    go(5);
    chk("sg word", u_mem.mem[257], u_mem.mem[708]);
    chk("sg word", u_mem.mem[258], u_mem.mem[709]);
    chk("sg done", 1, ndone[5]);
    // high priority beats a lower channel number
    desc(6, 0, 32'h400, 32'hc00, cw(2, 2, 2, 0, 10'h0, 3'h1));
    desc(7, 0, 32'h404, 32'hc04, cw(2, 2, 2, 0, 10'h0, 3'h1));
    wb(1'b1, `DSQ_R_HIPRI, 32'h80);
    order.delete();
    go(6);
    chk("prio unused", 1, ndone[6]);
    order.delete();
    desc(6, 0, 32'h400, 32'hc00, cw(2, 2, 2, 0, 10'h0, 3'h1));
    wb(1'b1, `DSQ_R_SWREQ, 32'hc0);
    settle;
    chk("prio first", 7, order.size() > 0 ? order[0] : 0);
    wrap_up;
  end
endmodule
